// ### verilog/spi_crc_pkg.sv
/*
 * Shared constants, frame phases and CRC helpers of the SPI CRC command path.
 * Assumes nothing of its surroundings.
 */
package spi_crc_pkg;
    localparam logic [3:0] OP_READ_CRC = 4'hb;
    localparam logic [3:0] OP_WRITE_CRC = 4'ha;
    localparam logic [3:0] OP_WRITE_SAFE = 4'hc;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [11:0] RAM_LO = 12'h400;
    localparam logic [11:0] RAM_HI = 12'hbff;
    localparam logic [9:0] SAFE_REG_BYTES = 10'h001;
    localparam logic [9:0] SAFE_RAM_BYTES = 10'h004;
    localparam int ENTRY_W = 45;
    localparam int ENT_RAM = 44;
    localparam int ENT_ADDR = 32;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_CNT, ST_DATA, ST_CRC, ST_END, ST_SKIP
    } phase_e;

    // One serial step of the frame CRC, most significant bit first.
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
    endfunction : crc_step

    // Next word address in RAM, wrapping from the top back to the base.
    function automatic logic [11:0] ram_next(input logic [11:0] a);
        ram_next = (a[11:2] == RAM_HI[11:2]) ? RAM_LO : a + 12'h004;
    endfunction : ram_next

    function automatic logic is_crc_op(input logic [3:0] op);
        is_crc_op = (op == OP_READ_CRC) || (op == OP_WRITE_CRC) ||
                    (op == OP_WRITE_SAFE);
    endfunction : is_crc_op

    // Filtered level behind a three-stage synchroniser: it follows the
    // pin only once the second and third stages agree.
    function automatic logic settled(input logic [2:0] s, input logic f);
        settled = (s[1] == s[2]) ? s[2] : f;
    endfunction : settled
endpackage : spi_crc_pkg

// ### verilog/spi_crc_fifo.sv
/*
 * Parameterised FIFO with a registered output stage.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module spi_crc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input logic core_clk,
    input logic rstn,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic out_valid;
        logic [WIDTH-1:0] out_data;
    } fifo_s;

    fifo_s st_reg;
    fifo_s st_next;
    logic do_push;
    logic do_load;

    assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = st_reg.out_valid;
    assign out_data = st_reg.out_data;

    always_comb begin
        st_next = st_reg;
        do_push = in_valid && in_ready;
        do_load = (st_reg.cnt != '0) && (!st_reg.out_valid || out_ready);
        if (st_reg.out_valid && out_ready) begin
            st_next.out_valid = 1'b0;
        end
        if (do_load) begin
            st_next.out_data = st_reg.mem[st_reg.rp];
            st_next.out_valid = 1'b1;
            st_next.rp = st_reg.rp + 1'b1;
        end
        if (do_push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(do_push) - (AW+1)'(do_load);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : spi_crc_fifo

// ### verilog/spi_crc_command_unit.sv
/*
 * CRC-protected command path of the SPI slave port: checked read, checked
 * write and guarded write to register space and word RAM, with frame CRC
 * and error pulses. Committed writes leave through a FIFO.
 * Assumes SPI mode 0, SCK much slower than core_clk, and rd_data valid in
 * the first cycle after an rd_en pulse.
 */
// Operation
// - Checked write: opcode, 12-bit address, count (bytes, words in RAM), data, 16-bit CRC.
// - Checked register write commits each byte on its closing falling edge.
// - Checked write compares received CRC at the end; mismatch flags.
// - Select released before last write CRC byte sets the short flag.
// - Select released before last read CRC byte is sent sets short flag.
// - Guarded register write: opcode, address, one data byte, CRC.
// - Guarded register byte stored only on CRC match, else flagged.
// - Checked read: opcode, address, count, data bytes out, then CRC.
// - RAM accesses force the two low address bits to zero.
// - RAM read fetches a word after the count and every fourth byte except the last.
// - Checked reads only send the CRC and never raise a mismatch.
// - Checked RAM write stores each full word; partial words drop.
// - Guarded RAM write: opcode, address, four data bytes, CRC.
// - Guarded RAM word stored only on CRC match, else flagged.
// - CRC polynomial 0x8005, stepped with every shifted bit before the CRC bytes.
// - CRC accumulator preset to all ones at each select assertion.
// - CRC covers opcode, address, count and data bytes.
// - On mismatch the computed CRC is captured into the status output.
`timescale 1ns/100ps
module spi_crc_command_unit
    import spi_crc_pkg::*;
(
    input logic core_clk,
    input logic rstn,
    input logic sck,
    input logic chip_select_low,
    input logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic rd_en,
    output logic rd_is_ram,
    output logic [11:0] rd_addr,
    input logic [31:0] rd_data,
    output logic wr_valid,
    input logic wr_ready,
    output logic wr_is_ram,
    output logic [11:0] wr_addr,
    output logic [31:0] wr_data,
    output logic crc_mismatch_flag,
    output logic crc_short_frame_flag,
    output logic [15:0] crc_status
);
    typedef struct packed {
        logic [2:0] sck_s;
        logic [2:0] cs_s;
        logic [2:0] sdi_s;
        logic sck_f;
        logic cs_f;
        logic sdi_f;
        phase_e state;
        logic [3:0] op;
        logic is_ram;
        logic [11:0] addr;
        logic [11:0] wr_at;
        logic [9:0] remaining;
        logic [2:0] bit_cnt;
        logic hdr2;
        logic [6:0] rx;
        logic [31:0] word;
        logic [1:0] lane;
        logic [15:0] crc;
        logic [7:0] crc_hi;
        logic crc_byte;
        logic done;
        logic commit_pend;
        logic [7:0] tx;
        logic sdo_oe;
        logic rd_en;
        logic rd_wait;
        logic [11:0] rd_addr;
        logic rd_is_ram;
        logic mismatch;
        logic short_frame;
        logic [15:0] crc_status;
        logic push_valid;
        logic [ENTRY_W-1:0] push_data;
    } unit_s;

    unit_s st_reg;
    unit_s st_next;
    logic fifo_ready;
    logic [ENTRY_W-1:0] wr_entry;
    logic sck_rise;
    logic sck_fall;
    logic cs_on;
    logic cs_off;
    logic bit_in;
    logic is_read;
    logic open_crc;
    logic [7:0] byte_in;
    logic last;
    logic ram;
    logic [7:0] next_tx;

    // =====================================================================
    // Pin edges
    // =====================================================================
    // A change counts once the second and third sampling stages agree.
    assign sck_rise = settled(st_reg.sck_s, st_reg.sck_f) && !st_reg.sck_f;
    assign sck_fall = !settled(st_reg.sck_s, st_reg.sck_f) && st_reg.sck_f;
    assign cs_on = !settled(st_reg.cs_s, st_reg.cs_f) && st_reg.cs_f;
    assign cs_off = settled(st_reg.cs_s, st_reg.cs_f) && !st_reg.cs_f;
    assign bit_in = settled(st_reg.sdi_s, st_reg.sdi_f);
    assign is_read = (st_reg.op == OP_READ_CRC);
    assign open_crc = is_crc_op(st_reg.op) && !st_reg.done &&
                      (st_reg.state inside {ST_CMD, ST_CNT, ST_DATA,
                                            ST_CRC});

    // =====================================================================
    // Outputs
    // =====================================================================
    assign sdo = st_reg.tx[7];
    assign sdo_oe = st_reg.sdo_oe;
    assign rd_en = st_reg.rd_en;
    assign rd_is_ram = st_reg.rd_is_ram;
    assign rd_addr = st_reg.rd_addr;
    assign crc_mismatch_flag = st_reg.mismatch;
    assign crc_short_frame_flag = st_reg.short_frame;
    assign crc_status = st_reg.crc_status;
    assign wr_is_ram = wr_entry[ENT_RAM];
    assign wr_addr = wr_entry[ENT_ADDR +: 12];
    assign wr_data = wr_entry[31:0];

    // =====================================================================
    // Write queue
    // =====================================================================
    spi_crc_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(st_reg.push_valid),
        .in_ready(fifo_ready),
        .in_data(st_reg.push_data),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_entry)
    );

    // =====================================================================
    // Frame engine
    // =====================================================================
    always_comb begin
        st_next = st_reg;
        byte_in = {st_reg.rx, bit_in};
        last = (st_reg.bit_cnt == 3'd7);
        ram = (st_reg.addr[11:8] >= RAM_LO[11:8]) &&
              (st_reg.addr[11:8] <= RAM_HI[11:8]);
        // Byte order inside a RAM word follows the address: lane 0 low.
        if (st_reg.state == ST_CRC) begin
            next_tx = st_reg.crc_byte ? st_reg.crc[7:0] :
                      st_reg.crc[15:8];
        end else begin
            next_tx = st_reg.is_ram ? st_reg.word[8*st_reg.lane +: 8] :
                      st_reg.word[7:0];
        end
        st_next.mismatch = 1'b0;
        st_next.short_frame = 1'b0;
        st_next.rd_en = 1'b0;
        st_next.rd_wait = st_reg.rd_en;
        st_next.sck_s = {st_reg.sck_s[1:0], sck};
        st_next.cs_s = {st_reg.cs_s[1:0], chip_select_low};
        st_next.sdi_s = {st_reg.sdi_s[1:0], sdi};
        st_next.sck_f = settled(st_reg.sck_s, st_reg.sck_f);
        st_next.cs_f = settled(st_reg.cs_s, st_reg.cs_f);
        st_next.sdi_f = settled(st_reg.sdi_s, st_reg.sdi_f);
        if (st_reg.rd_wait) begin
            st_next.word = rd_data;
        end
        if (st_reg.push_valid && fifo_ready) begin
            st_next.push_valid = 1'b0;
        end

        if (cs_off) begin
            st_next.short_frame = open_crc;
            st_next.state = ST_IDLE;
            st_next.sdo_oe = 1'b0;
            st_next.commit_pend = 1'b0;
        end else if (cs_on) begin
            st_next.state = ST_CMD;
            st_next.crc = CRC_INIT;
            st_next.op = 4'h0;
            st_next.bit_cnt = 3'd0;
            st_next.hdr2 = 1'b0;
            st_next.done = 1'b0;
            st_next.crc_byte = 1'b0;
        end else if (sck_rise) begin
            st_next.rx = byte_in[6:0];
            st_next.bit_cnt = st_reg.bit_cnt + 3'd1;
            case (st_reg.state)
                ST_CMD: begin
                    st_next.crc = crc_step(st_reg.crc, bit_in);
                    if (last && !st_reg.hdr2) begin
                        st_next.op = byte_in[7:4];
                        st_next.addr[11:8] = byte_in[3:0];
                        st_next.hdr2 = 1'b1;
                        if (!is_crc_op(byte_in[7:4])) begin
                            st_next.state = ST_SKIP;
                        end
                    end else if (last) begin
                        st_next.is_ram = ram;
                        st_next.addr[7:0] = {byte_in[7:2],
                            ram ? 2'b00 : byte_in[1:0]};
                        st_next.lane = 2'd0;
                        if (st_reg.op == OP_WRITE_SAFE) begin
                            st_next.remaining = ram ? SAFE_RAM_BYTES :
                                SAFE_REG_BYTES;
                            st_next.state = ST_DATA;
                        end else begin
                            st_next.state = ST_CNT;
                        end
                    end
                end
                ST_CNT: begin
                    st_next.crc = crc_step(st_reg.crc, bit_in);
                    if (last) begin
                        // RAM counts words, register space counts bytes.
                        st_next.remaining = st_reg.is_ram ?
                            {byte_in, 2'b00} : {2'b00, byte_in};
                        st_next.state = (byte_in == 8'h00) ? ST_CRC :
                            ST_DATA;
                        if (is_read) begin
                            st_next.sdo_oe = 1'b1;
                            st_next.rd_en = (byte_in != 8'h00);
                            st_next.rd_addr = st_reg.addr;
                            st_next.rd_is_ram = st_reg.is_ram;
                        end
                    end
                end
                ST_DATA: begin
                    // Read data is covered as it leaves on the line.
                    st_next.crc = crc_step(st_reg.crc,
                        is_read ? st_reg.tx[7] : bit_in);
                    if (last) begin
                        st_next.remaining = st_reg.remaining - 10'd1;
                        st_next.lane = st_reg.lane + 2'd1;
                        if (!st_reg.is_ram) begin
                            st_next.addr = st_reg.addr + 12'd1;
                        end else if (st_reg.lane == 2'd3) begin
                            st_next.addr = ram_next(st_reg.addr);
                        end
                        if (!is_read) begin
                            if (!st_reg.is_ram || st_reg.lane == 2'd0) begin
                                st_next.wr_at = st_reg.addr;
                            end
                            if (st_reg.is_ram) begin
                                st_next.word[8*st_reg.lane +: 8] = byte_in;
                            end else begin
                                st_next.word = {24'h000000, byte_in};
                            end
                            st_next.commit_pend =
                                (st_reg.op == OP_WRITE_CRC) &&
                                (!st_reg.is_ram ||
                                 st_reg.lane == 2'd3);
                        end else if (st_reg.remaining != 10'd1 &&
                            (!st_reg.is_ram || st_reg.lane == 2'd3)) begin
                            st_next.rd_en = 1'b1;
                            st_next.rd_addr = st_reg.is_ram ?
                                ram_next(st_reg.addr) :
                                st_reg.addr + 12'd1;
                        end
                        if (st_reg.remaining == 10'd1) begin
                            st_next.state = ST_CRC;
                        end
                    end
                end
                ST_CRC: begin
                    if (last && !st_reg.crc_byte) begin
                        st_next.crc_byte = 1'b1;
                        st_next.crc_hi = byte_in;
                    end else if (last) begin
                        st_next.done = 1'b1;
                        st_next.state = ST_END;
                        if (!is_read &&
                            {st_reg.crc_hi, byte_in} != st_reg.crc) begin
                            st_next.mismatch = 1'b1;
                            st_next.crc_status = st_reg.crc;
                        end else if (st_reg.op == OP_WRITE_SAFE) begin
                            st_next.push_valid = 1'b1;
                            st_next.push_data = {st_reg.is_ram,
                                st_reg.wr_at, st_reg.word};
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (sck_fall) begin
            if (st_reg.commit_pend) begin
                st_next.commit_pend = 1'b0;
                st_next.push_valid = 1'b1;
                st_next.push_data = {st_reg.is_ram, st_reg.wr_at,
                                     st_reg.word};
            end
            if (st_reg.sdo_oe &&
                (st_reg.state == ST_DATA || st_reg.state == ST_CRC)) begin
                st_next.tx = (st_reg.bit_cnt == 3'h0) ? next_tx :
                    {st_reg.tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence start_s;
        cs_on;
    endsequence
    sequence stop_s;
        cs_off;
    endsequence
    sequence commit_s;
        sck_fall && !cs_off ##0 st_reg.commit_pend;
    endsequence

    crc_preset_a: assert property (start_s |=> st_reg.crc == CRC_INIT)
        else $error("CRC not preset at frame start.");
    frame_end_a: assert property (stop_s |=> st_reg.state == ST_IDLE)
        else $error("Frame not ended by select release.");
    short_frame_a: assert property (stop_s ##0 open_crc |=>
        crc_short_frame_flag && !sdo_oe)
        else $error("Short frame not flagged.");
    read_quiet_a: assert property (crc_mismatch_flag |->
        $past(st_reg.op) != OP_READ_CRC)
        else $error("Mismatch raised on a read.");
    status_grab_a: assert property (crc_mismatch_flag |->
        crc_status == $past(st_reg.crc))
        else $error("Computed CRC not captured.");
    end_check_a: assert property (crc_mismatch_flag |->
        st_reg.state == ST_END && st_reg.done)
        else $error("Mismatch outside frame end.");
    byte_commit_a: assert property (commit_s |=>
        st_reg.push_valid && st_reg.push_data[ENT_ADDR +: 12] ==
        $past(st_reg.wr_at))
        else $error("Byte not committed on falling edge.");
    word_commit_a: assert property (commit_s ##0 st_reg.is_ram |->
        st_reg.lane == 2'd0)
        else $error("Partial RAM word committed.");
    safe_guard_a: assert property ($rose(st_reg.push_valid) &&
        st_reg.op == OP_WRITE_SAFE |-> st_reg.done && !crc_mismatch_flag)
        else $error("Guarded write stored without match.");
    ram_align_a: assert property (rd_en && rd_is_ram |->
        rd_addr[1:0] == 2'b00 ##2 st_reg.word == $past(rd_data))
        else $error("Unaligned RAM fetch.");
endmodule : spi_crc_command_unit

// ### tb/spi_host_model.sv
/*
 * Host side of the SPI link: a mode 0 master that sends tx_buf and
 * captures sdo into rx_buf. Assumes core_clk at 4 ns; the link clock
 * runs at 160 ns and stands low outside frames.
 */
`timescale 1ns/100ps
module spi_host_model (
    input wire logic core_clk,
    output logic sck,
    output logic chip_select_low,
    output logic sdi,
    input wire logic sdo
);
    logic [7:0] tx_buf [0:15];
    logic [7:0] rx_buf [0:15];

    initial begin
        sck = 1'b0;
        chip_select_low = 1'b1;
        sdi = 1'b1;
    end

    task automatic half;
        repeat (20) @(negedge core_clk);
    endtask : half

    // Sends n bytes in one frame; select framing bounds it.
    task automatic run(input int n);
        chip_select_low = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            for (int k = 7; k >= 0; k--) begin
                sdi = tx_buf[i][k];
                half();
                rx_buf[i][k] = sdo;
                sck = 1'b1;
                half();
                sck = 1'b0;
            end
        end
        half();
        sdi = ~sdi;
        chip_select_low = 1'b1;
        half();
    endtask : run
endmodule : spi_host_model

// ### tb/tb.sv
/*
 * Self-checking bench of the SPI CRC command unit.
 * Assumes the host model and a read-data responder of half a cycle latency.
 */
`timescale 1ns/100ps
module tb
    import spi_crc_pkg::*;
;
    logic core_clk, rstn, sck, chip_select_low, sdi, sdo, sdo_oe;
    logic rd_en, rd_is_ram, wr_valid, wr_ready, wr_is_ram;
    logic crc_mismatch_flag, crc_short_frame_flag, exp_ram;
    logic [11:0] rd_addr, wr_addr;
    logic [31:0] rd_data, wr_data;
    logic [15:0] crc_status, lfsr, rdy;
    int n_fail, n_compared, n_mis, n_short, n_oe;
    logic [44:0] wq[$];
    logic [7:0] q[$];

    spi_crc_command_unit i_spi_crc_command_unit (.core_clk(core_clk),
        .rstn(rstn), .sck(sck), .chip_select_low(chip_select_low),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .rd_en(rd_en),
        .rd_is_ram(rd_is_ram), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_is_ram(wr_is_ram),
        .wr_addr(wr_addr), .wr_data(wr_data),
        .crc_mismatch_flag(crc_mismatch_flag),
        .crc_short_frame_flag(crc_short_frame_flag),
        .crc_status(crc_status));
    spi_host_model host (.core_clk(core_clk), .sck(sck),
        .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo));

    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    function automatic logic [7:0] rnd();
        lfsr = step(lfsr);
        return lfsr[7:0];
    endfunction : rnd
    function automatic logic [31:0] mem(input logic [11:0] a);
        return {4'h0, a, 4'h0, a} ^ 32'h5a3c96e1;
    endfunction : mem
    function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i])
            for (int k = 7; k >= 0; k--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? 16'h8005 : 16'h0);
        return c;
    endfunction : crc_of

    task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic hdr(input logic [3:0] op, input logic [11:0] a);
        q = {};
        q.push_back({op, a[11:8]});
        q.push_back(a[7:0]);
    endtask : hdr
    task automatic add_crc(input logic flip);
        logic [15:0] c;
        c = crc_of(q) ^ {15'h0, flip};
        q.push_back(c[15:8]);
        q.push_back(c[7:0]);
    endtask : add_crc
    task automatic frame(input int n, input int em, input int es);
        int m0, s0, o0;
        m0 = n_mis;
        s0 = n_short;
        o0 = n_oe;
        foreach (q[i]) host.tx_buf[i] = q[i];
        host.run(n);
        repeat (300) @(negedge core_clk);
        chk(n_mis - m0, em);
        chk(n_short - s0, es);
        chk(wq.size(), 0);
        chk(sdo_oe, 0);
        chk(n_oe != o0, q[0][7:4] == OP_READ_CRC);
        $display("test done: %0d bytes", n);
    endtask : frame

    // ==========================================================
    // Clock, responders and output watcher.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        rdy <= step(rdy);
        wr_ready <= rdy[0] | rdy[5];
        if (rd_en === 1'b1)
            rd_data <= mem(rd_addr);
    end
    always @(posedge core_clk) begin
        if (rstn && crc_mismatch_flag === 1'b1) n_mis++;
        if (rstn && crc_short_frame_flag === 1'b1) n_short++;
        if (rstn && sdo_oe === 1'b1) n_oe++;
        if (rstn && rd_en === 1'b1) chk(rd_is_ram, exp_ram);
        if (rstn && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (wq.size() == 0) chk(1, 0);
            else chk({wr_is_ram, wr_addr, wr_data}, wq.pop_front());
        end
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence.
    initial begin
        logic [7:0] d;
        logic [15:0] c;
        logic [31:0] w, e;
        logic [11:0] a;
        int nd;
        rstn = 1'b0;
        lfsr = 16'hd9b5;
        rdy = 16'hd9b5;
        wr_ready = 1'b0;
        rd_data = 32'h0;
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        repeat (8) @(negedge core_clk);
        for (int f = 0; f < 2; f++) begin
            hdr(OP_WRITE_CRC, 12'hffe);
            q.push_back(f ? 8'h01 : 8'h03);
            for (int i = 0; i < (f ? 1 : 3); i++) begin
                d = rnd();
                q.push_back(d);
                wq.push_back({1'b0, 12'hffe + 12'(i), 24'h0, d});
            end
            c = crc_of(q);
            add_crc(f[0]);
            frame(q.size(), f, 0);
        end
        chk(crc_status, c);
        for (int f = 0; f < 4; f++) begin
            hdr(OP_WRITE_SAFE, f[1] ? 12'h806 : 12'h123);
            w = {rnd(), rnd(), rnd(), rnd()};
            for (int i = 0; i < (f[1] ? 4 : 1); i++)
                q.push_back(w[8*i +: 8]);
            if (!f[0])
                wq.push_back(f[1] ? {1'b1, 12'h804, w} :
                             {1'b0, 12'h123, 24'h0, w[7:0]});
            add_crc(f[0]);
            frame(q.size(), f[0], 0);
        end
        hdr(OP_WRITE_CRC, 12'h7fd);
        q.push_back(8'h02);
        w = {rnd(), rnd(), rnd(), rnd()};
        for (int i = 0; i < 6; i++) q.push_back(w[8*(i%4) +: 8]);
        wq.push_back({1'b1, 12'h7fc, w});
        frame(q.size(), 0, 1);
        hdr(4'h2, 12'h400);
        q.push_back(8'haa);
        frame(3, 0, 0);
        hdr(OP_WRITE_SAFE, 12'h050);
        q.push_back(8'h11);
        frame(3, 0, 1);
        for (int f = 0; f < 3; f++) begin
            a = f ? 12'h803 : 12'h0fe;
            nd = f ? 4 : 2;
            exp_ram = (f != 0);
            hdr(OP_READ_CRC, a);
            q.push_back(f ? 8'h01 : 8'h02);
            for (int i = 0; i < nd + 2; i++) q.push_back(8'h00);
            frame(nd + 5 - (f == 2), 0, f == 2);
            q = q[0:2+nd];
            for (int i = 0; i < nd; i++) begin
                e = f ? mem(12'h800) >> (8*i) : mem(a + 12'(i));
                q[3+i] = e[7:0];
                chk(host.rx_buf[3+i], e[7:0]);
            end
            c = crc_of(q);
            if (f < 2)
                chk({host.rx_buf[3+nd], host.rx_buf[4+nd]}, c);
        end
        wrap_up();
    end
endmodule : tb
